// *** hdl/smc_serial_mode_ctrl.sv ***
// serial programming mode entry, exit and link shifter for the on-chip flash
// Function
// - device enters serial mode on first programmer clock under permitted CPU states.
// - entry only while the serial mode enable pin is high.
// - during serial mode, NMI and external interrupt 0 and 1 are held pending.
// - releasing reset during a session entered from reset exits serial mode at once, aborting.
// - low level on the enable pin exits serial mode at once.
// - normal completion of an operation exits serial mode by itself.
// - held interrupts release stop mode when the operation finishes.
// - link is one clock input from the programmer and one two-way data pin.
// - entry from stop leaves RAM, timers and peripherals unchanged.
module smc_serial_mode_ctrl
    import smc_pkg::*;
(
    input  wire logic              clk_sys_in,
    input  wire logic              rst_n_in,
    input  wire logic              programmer_serial_clock_in,
    input  wire logic              programmer_serial_data_in,
    output      smc_pin_out_t      programmer_serial_data_out,
    input  wire logic              serial_mode_enable_pin_in,
    input  wire logic              mode_entry_high_voltage_pin_in,
    input  wire logic              cpu_reset_held_in,
    input  wire logic              cpu_stop_in,
    input  wire logic              op_done_in,
    input  wire logic [BYTE_W-1:0] tx_byte_in,
    input  wire logic              tx_load_in,
    output      logic              tx_ready_out,
    output      logic [BYTE_W-1:0] rx_byte_out,
    output      logic              rx_valid_out,
    input  wire smc_irq_t          irq_req_in,
    input  wire smc_irq_t          pend_clear_in,
    output      smc_irq_t          irq_to_cpu_out,
    output      smc_irq_t          irq_pending_out,
    output      logic              serial_mode_out,
    output      logic              periph_hold_out,
    output      logic              stop_release_out,
    output      logic              op_abort_out,
    output      logic              op_end_out
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        smc_state_t           state;
        logic [SYNC_W-1:0]    clk_sync;
        logic [SYNC_W-1:0]    dat_sync;
        logic [SYNC_W-1:0]    en_sync;
        logic [SYNC_W-1:0]    hv_sync;
        logic                 clk_prev;
        logic                 from_reset;
        smc_irq_t             pend;
        logic [BYTE_W-1:0]    rx_shift;
        logic [BITCNT_W-1:0]  rx_cnt;
        logic [BYTE_W-1:0]    rx_byte;
        logic                 rx_valid;
        logic [BYTE_W-1:0]    tx_shift;
        logic [BITCNT_W-1:0]  tx_cnt;
        logic                 tx_busy;
        smc_exit_t            exit_cause;
        logic                 stop_release;
    } smc_regs_t;

    localparam smc_regs_t REGS_RST = '{
        state:        ST_IDLE,
        clk_sync:     SYNC_RST,
        dat_sync:     SYNC_HIGH,
        en_sync:      SYNC_RST,
        hv_sync:      SYNC_RST,
        clk_prev:     1'b0,
        from_reset:   1'b0,
        pend:         IRQ_NONE,
        rx_shift:     BYTE_RST,
        rx_cnt:       BITCNT_RST,
        rx_byte:      BYTE_RST,
        rx_valid:     1'b0,
        tx_shift:     BYTE_RST,
        tx_cnt:       BITCNT_RST,
        tx_busy:      1'b0,
        exit_cause:   EXIT_NONE,
        stop_release: 1'b0
    };

    smc_regs_t q;
    smc_regs_t d;

    logic sclk_rise;
    logic sclk_fall;
    logic enable_lvl;
    logic hv_lvl;
    logic dat_lvl;
    logic cpu_parked;

    function automatic logic is_active(input smc_state_t st);
        return st == ST_ACTIVE;
    endfunction : is_active

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d = q;

        // two-flop samplers; the logic reads only the second stage
        d.clk_sync = {q.clk_sync[0], programmer_serial_clock_in};
        d.dat_sync = {q.dat_sync[0], programmer_serial_data_in};
        d.en_sync  = {q.en_sync[0], serial_mode_enable_pin_in};
        d.hv_sync  = {q.hv_sync[0], mode_entry_high_voltage_pin_in};
        d.clk_prev = q.clk_sync[1];

        sclk_rise  = q.clk_sync[1] & ~q.clk_prev;
        sclk_fall  = ~q.clk_sync[1] & q.clk_prev;
        enable_lvl = q.en_sync[1];
        hv_lvl     = q.hv_sync[1];
        dat_lvl    = q.dat_sync[1];
        cpu_parked = cpu_reset_held_in | cpu_stop_in;

        d.rx_valid     = 1'b0;
        d.stop_release = 1'b0;
        d.exit_cause   = EXIT_NONE;

        // a request landing in the clear cycle survives: set wins
        d.pend = q.pend & ~pend_clear_in;
        if (is_active(q.state)) begin
            d.pend = d.pend | irq_req_in;
        end

        case (q.state)
            ST_IDLE: begin
                d.rx_cnt  = BITCNT_RST;
                d.tx_cnt  = BITCNT_RST;
                d.tx_busy = 1'b0;
                // the first programmer clock edge is the start of the operation
                if (sclk_rise && hv_lvl && enable_lvl && cpu_parked) begin
                    d.state      = ST_ACTIVE;
                    d.from_reset = cpu_reset_held_in;
                    d.rx_shift   = {q.rx_shift[BYTE_W-2:0], dat_lvl};
                    d.rx_cnt     = BITCNT_ONE;
                end
            end
            ST_ACTIVE: begin
                if (!enable_lvl) begin
                    d.state      = ST_IDLE;
                    d.exit_cause = EXIT_ENABLE;
                    d.tx_busy    = 1'b0;
                end else if (q.from_reset && !cpu_reset_held_in) begin
                    // flash contents are suspect after this abort
                    d.state      = ST_IDLE;
                    d.exit_cause = EXIT_RESET;
                    d.tx_busy    = 1'b0;
                end else if (op_done_in) begin
                    d.state        = ST_IDLE;
                    d.exit_cause   = EXIT_DONE;
                    d.tx_busy      = 1'b0;
                    d.stop_release = (|d.pend) & cpu_stop_in;
                end else begin
                    if (sclk_rise) begin
                        d.rx_shift = {q.rx_shift[BYTE_W-2:0], dat_lvl};
                        d.rx_cnt   = q.rx_cnt + BITCNT_ONE;
                        if (q.rx_cnt == BITCNT_LAST) begin
                            d.rx_byte  = {q.rx_shift[BYTE_W-2:0], dat_lvl};
                            d.rx_valid = 1'b1;
                        end
                    end
                    // reply bits change on the falling edge, sampled on the rise
                    if (!q.tx_busy && tx_load_in) begin
                        d.tx_shift = tx_byte_in;
                        d.tx_cnt   = BITCNT_RST;
                        d.tx_busy  = 1'b1;
                    end else if (q.tx_busy && sclk_fall) begin
                        d.tx_shift = {q.tx_shift[BYTE_W-2:0], 1'b1};
                        d.tx_cnt   = q.tx_cnt + BITCNT_ONE;
                        if (q.tx_cnt == BITCNT_LAST) begin
                            d.tx_busy = 1'b0;
                        end
                    end
                end
            end
            default: begin
                d.state = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            q <= REGS_RST;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // the pin is driven only while a reply byte is shifting out
    assign programmer_serial_data_out.dat  = q.tx_shift[BYTE_W-1];
    assign programmer_serial_data_out.oe_n = ~q.tx_busy;

    assign tx_ready_out    = is_active(q.state) & ~q.tx_busy;
    assign rx_byte_out     = q.rx_byte;
    assign rx_valid_out    = q.rx_valid;
    assign serial_mode_out = is_active(q.state);

    // gated off while the session runs, then delivered from the held copy
    assign irq_to_cpu_out  = is_active(q.state) ? IRQ_NONE
                                                : (irq_req_in | q.pend);
    assign irq_pending_out = q.pend;

    // a stop-mode session must not disturb RAM, timers or peripherals
    assign periph_hold_out  = is_active(q.state) & ~q.from_reset;
    assign stop_release_out = q.stop_release;
    assign op_abort_out     = (q.exit_cause == EXIT_RESET) | (q.exit_cause == EXIT_ENABLE);
    assign op_end_out       = (q.exit_cause == EXIT_DONE);

endmodule : smc_serial_mode_ctrl

// *** hdl/smc_pkg.sv ***
// constants and types for the serial flash mode controller
package smc_pkg;

    localparam int unsigned BYTE_W    = 8;
    localparam int unsigned BITCNT_W  = 3;
    localparam int unsigned SYNC_W    = 2;
    localparam logic [BITCNT_W-1:0] BITCNT_LAST  = 3'h7;
    localparam logic [BITCNT_W-1:0] BITCNT_RST   = 3'h0;
    localparam logic [BITCNT_W-1:0] BITCNT_ONE   = 3'h1;
    localparam logic [BYTE_W-1:0]   BYTE_RST     = 8'h00;
    localparam logic [SYNC_W-1:0]   SYNC_RST     = 2'h0;
    // the data pin idles high through its pull-up, so the sampler starts high
    localparam logic [SYNC_W-1:0]   SYNC_HIGH    = 2'h3;

    // held interrupt group: one bit per request source
    typedef struct packed {
        logic ext1;
        logic ext0;
        logic nmi;
    } smc_irq_t;

    localparam smc_irq_t IRQ_NONE = 3'h0;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_ACTIVE = 2'b10
    } smc_state_t;

    typedef enum logic [1:0] {
        EXIT_NONE   = 2'h0,
        EXIT_DONE   = 2'h1,
        EXIT_RESET  = 2'h2,
        EXIT_ENABLE = 2'h3
    } smc_exit_t;

    // serial data pin as two signals; oe_n low while the device drives
    typedef struct packed {
        logic dat;
        logic oe_n;
    } smc_pin_out_t;

endpackage : smc_pkg

// *** tb/smc_props.sv ***
// concurrent checks on the serial mode controller ports
module smc_props
    import smc_pkg::*;
(
    input wire logic     clk_sys_in,
    input wire logic     rst_n_in,
    input wire logic     serial_mode_enable_pin_in,
    input wire logic     cpu_reset_held_in,
    input wire logic     cpu_stop_in,
    input wire logic     op_done_in,
    input wire smc_irq_t irq_req_in,
    input wire smc_irq_t irq_to_cpu_out,
    input wire smc_irq_t irq_pending_out,
    input wire logic     serial_mode_out,
    input wire logic     periph_hold_out,
    input wire logic     stop_release_out,
    input wire logic     op_abort_out,
    input wire logic     op_end_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // mode drops in the same cycle as an abort pulse or an end pulse
    sequence s_left;
        !serial_mode_out && (op_abort_out || op_end_out);
    endsequence
    sequence s_entry;
        $rose(serial_mode_out);
    endsequence
    a_irq_masked: assert property (serial_mode_out |-> irq_to_cpu_out == IRQ_NONE)
        else $error("request passed in serial mode");
    a_irq_held: assert property (serial_mode_out && irq_req_in.nmi |=> irq_pending_out.nmi)
        else $error("request not held");
    a_entry_cpu: assert property (s_entry |-> $past(cpu_reset_held_in || cpu_stop_in))
        else $error("entry with cpu running");
    a_entry_enable: assert property (s_entry |-> $past(serial_mode_enable_pin_in, 3))
        else $error("entry with enable low");
    a_enable_exit: assert property (serial_mode_out && !serial_mode_enable_pin_in |-> ##[1:4] s_left)
        else $error("no exit on enable low");
    a_done_exit: assert property (serial_mode_out && op_done_in |=> s_left)
        else $error("no exit on completion");
    a_reset_abort: assert property (serial_mode_out && !periph_hold_out && $fell(cpu_reset_held_in) |=> s_left)
        else $error("no exit on reset release");
    a_stop_release: assert property (stop_release_out |-> op_end_out && $past(cpu_stop_in))
        else $error("stray stop release");
    a_hold_kind: assert property (s_entry |-> periph_hold_out == $past(!cpu_reset_held_in))
        else $error("peripheral hold wrong");
endmodule : smc_props
bind smc_serial_mode_ctrl smc_props u_props (.*);

// *** tb/smc_prog_model.sv ***
// programmer model: frames the serial clock, drives or reads the data line
module smc_prog_model
    import smc_pkg::*;
(
    input  wire logic         cpu_ok_in,
    input  wire smc_pin_out_t dev_pin_in,
    output      logic         sclk_out,
    output      logic         sdat_out,
    output      logic         err_out,
    output      logic [7:0]   rx_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic drv = 1'b0;
    logic val = 1'b1;
    initial sclk_out = 1'b0;
    // a released line rises through its pull-up instead of keeping the old bit
    assign sdat_out = !dev_pin_in.oe_n ? dev_pin_in.dat : (drv ? val : 1'b1);
    // clock stands low between frames; half period 100 ns
    task automatic xfer(input logic [7:0] b, input logic send);
        err_out = !cpu_ok_in;
        if (err_out) return;
        for (int i = 7; i >= 0; i--) begin
            drv = send;
            val = b[i];
            #100 sclk_out = 1'b1;
            rx_out[i] = sdat_out;
            #100 sclk_out = 1'b0;
        end
        drv = 1'b0;
    endtask : xfer
endmodule : smc_prog_model

// *** tb/tb_smc_serial_mode_ctrl.sv ***
// self-checking bench for the serial mode controller
module tb_smc_serial_mode_ctrl
    import smc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, hv = 1'b1, c_rst = 1'b1, c_stp = 1'b0;
    logic done = 1'b0, ld = 1'b0, m;
    logic [7:0] txb = 8'h00, erx = 8'h00;
    smc_irq_t req = IRQ_NONE, clr = IRQ_NONE, icpu, ipend;
    smc_pin_out_t pin;
    logic sclk, sdat, perr, rdy, rxv, mode, hold, srel, abrt, oend;
    logic [7:0] prx, rxb;
    int n_fail = 0, compares = 0, cyc = 0, n_rxv = 0;
    // {cpu reset, cpu stop, enable, high voltage} beside the expected mode
    logic [4:0] rows [5] = '{5'b10111, 5'b01111, 5'b10010, 5'b10100, 5'b00110};
    always #12.5 clk = ~clk;
    smc_serial_mode_ctrl dut (.clk_sys_in(clk), .rst_n_in(rst_n),
        .programmer_serial_clock_in(sclk), .programmer_serial_data_in(sdat),
        .programmer_serial_data_out(pin), .serial_mode_enable_pin_in(en),
        .mode_entry_high_voltage_pin_in(hv), .cpu_reset_held_in(c_rst), .cpu_stop_in(c_stp),
        .op_done_in(done), .tx_byte_in(txb), .tx_load_in(ld), .tx_ready_out(rdy),
        .rx_byte_out(rxb), .rx_valid_out(rxv), .irq_req_in(req), .pend_clear_in(clr),
        .irq_to_cpu_out(icpu), .irq_pending_out(ipend), .serial_mode_out(mode),
        .periph_hold_out(hold), .stop_release_out(srel), .op_abort_out(abrt), .op_end_out(oend));
    smc_prog_model pm (.cpu_ok_in(c_rst | c_stp), .dev_pin_in(pin), .sclk_out(sclk),
        .sdat_out(sdat), .err_out(perr), .rx_out(prx));
    ////////////////////////////////////////////////////////////////////////////
    task automatic step(input int n = 1);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_bit(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask : chk_bit
    task automatic chk_irq(input smc_irq_t got, input smc_irq_t exp);
        chk({5'h00, got}, {5'h00, exp});
    endtask : chk_irq
    task automatic test_done;
        if (n_fail == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        step(16);
        rst_n = 1'b1;
        foreach (rows[i]) begin
            {c_rst, c_stp, en, hv, m} = rows[i];
            step(4);
            pm.xfer(8'h50 + 8'(i), 1'b1);
            step(6);
            // a refused frame must leave the last accepted byte in place
            if (m) begin
                erx = 8'h50 + 8'(i);
            end
            chk_bit(mode, m);
            chk_bit(perr, !(c_rst | c_stp));
            chk_bit(hold, m & c_stp);
            chk(rxb, erx);
            done = 1'b1;
            step;
            done = 1'b0;
            chk_bit(oend, m);
        end
        // reset-held session with a held request, aborted by reset release
        {c_rst, c_stp, en, hv} = 4'b1011;
        step(4);
        pm.xfer(8'h3C, 1'b1);
        step;
        req = 3'h1;
        #1 chk_irq(icpu, IRQ_NONE);
        step;
        req = IRQ_NONE;
        c_rst = 1'b0;
        chk_irq(ipend, 3'h1);
        step;
        chk_bit(abrt, 1'b1);
        chk_bit(mode, 1'b0);
        chk_irq(icpu, 3'h1);
        clr = 3'h7;
        step;
        // stop session rewrites after the abort; reply read back, held request frees stop
        {clr, c_stp} = {IRQ_NONE, 1'b1};
        step(4);
        pm.xfer(8'h81, 1'b1);
        step(4);
        chk_bit(rdy, 1'b1);
        {txb, ld} = {8'hC3, 1'b1};
        step;
        ld = 1'b0;
        pm.xfer(8'h00, 1'b0);
        step(4);
        chk(prx, 8'hC3);
        chk(rxb, 8'hC3);
        req = 3'h4;
        step;
        {req, done} = {IRQ_NONE, 1'b1};
        step;
        done = 1'b0;
        chk_bit(srel, 1'b1);
        chk_bit(oend, 1'b1);
        clr = 3'h7;
        step;
        clr = IRQ_NONE;
        pm.xfer(8'hFF, 1'b1);
        step(2);
        en = 1'b0;
        repeat (6) begin
            step;
            if (abrt === 1'b1) break;
        end
        chk_bit(abrt, 1'b1);
        chk_bit(mode, 1'b0);
        // six whole bytes crossed the link: two rows, abort, stop, reply, enable drop
        chk(8'(n_rxv), 8'h06);
        test_done;
    end
    always @(posedge clk) begin
        cyc++;
        if (rxv === 1'b1) begin
            n_rxv++;
        end
        if (cyc == 5000) begin
            n_fail++;
            test_done;
        end
    end
endmodule : tb_smc_serial_mode_ctrl
